// file: inc/cdis_consts.svh
// Constants of the character display instruction decoder.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef CDIS_CONSTS_SVH
`define CDIS_CONSTS_SVH

`define CDIS_CLK_NS        5
`define CDIS_T_CLEAR_NS    1520000
`define CDIS_T_HOME_NS     1520000
`define CDIS_T_CMD_NS      37000
`define CDIS_T_DATA_NS     43000
`define CDIS_T_BLINK_NS    400000000

`define CDIS_SPACE         8'h20
`define CDIS_AC_ZERO       7'h00
`define CDIS_L1_END        7'h27
`define CDIS_L2_BASE       7'h40
`define CDIS_L2_END        7'h67
`define CDIS_ONE_END       7'h4F
`define CDIS_LEN_TWO       7'h28
`define CDIS_LEN_ONE       7'h50
`define CDIS_FILL_LAST     7'h7F

`define CDIS_BIT_DIR       1
`define CDIS_BIT_SHIFT     0
`define CDIS_BIT_DON       2
`define CDIS_BIT_CUR       1
`define CDIS_BIT_BLINK     0
`define CDIS_BIT_SC        3
`define CDIS_BIT_RL        2
`define CDIS_BIT_DL        4
`define CDIS_BIT_N         3
`define CDIS_BIT_F         2

`define CDIS_RST_WIDE      1'b1
`define CDIS_RST_DIR       1'b1

`endif

// file: inc/cdis_pkg.sv
// Types shared by the display instruction decoder and its bus front end.
// No assumptions beyond a SystemVerilog compiler.
package cdis_pkg;

  typedef struct packed {
    logic       rs;
    logic       rw;
    logic [7:0] data;
  } cdis_xfer_t;

  typedef enum logic [1:0] {
    CDIS_IDLE = 2'b00,
    CDIS_FILL = 2'b01,
    CDIS_WAIT = 2'b10
  } cdis_state_t;

endpackage

// file: rtl/cdis_ram.sv
// Simple dual-port RAM with registered read data.
// Assumes one clock; contents are undefined until written.
`timescale 1ns/100ps
`default_nettype none
module cdis_ram #(
  parameter int WIDTH  = 8,
  parameter int DEPTH  = 128,
  parameter int ADDR_W = 7
) (
  input  wire logic              clk_sys,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule
`default_nettype wire

// file: rtl/cdis_bus.sv
// Parallel host bus front end: pin synchronisers, strobe edges, nibbles.
// Assumes the host keeps select and data steady around the enable edges.
`timescale 1ns/100ps
`default_nettype none
module cdis_bus (
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               reg_select,
  input  wire logic               rw,
  input  wire logic               en,
  input  wire logic [7:0]         data_in,
  input  wire logic               bus_width,
  input  wire logic [7:0]         rd_byte,
  output cdis_pkg::cdis_xfer_t    xfer,
  output logic                    xfer_valid,
  output logic                    cur_rs,
  output logic [7:0]              data_out,
  output logic                    data_oe
);

  logic [10:0] s1_reg;
  logic [10:0] s2_reg;
  logic        en_d_reg;
  logic        low_reg;
  logic [3:0]  hi_reg;
  logic [7:0]  dout_reg;
  logic        valid_reg;
  cdis_pkg::cdis_xfer_t xfer_reg;

  wire       rs_s   = s2_reg[10];
  wire       rw_s   = s2_reg[9];
  wire       en_s   = s2_reg[8];
  wire [7:0] d_s    = s2_reg[7:0];
  wire       en_fall = en_d_reg & ~en_s;
  // In the narrow mode the byte is done only on its second half
  wire       done   = en_fall & (bus_width | low_reg);
  wire [7:0] wbyte  = bus_width ? d_s : {hi_reg, d_s[7:4]};
  // Upper half goes out first on the upper lines
  wire [7:0] rsel   = (bus_width | ~low_reg) ? rd_byte
                                             : {rd_byte[3:0], 4'h0};

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_reg    <= 11'h000;
      s2_reg    <= 11'h000;
      en_d_reg  <= 1'b0;
      low_reg   <= 1'b0;
      hi_reg    <= 4'h0;
      dout_reg  <= 8'h00;
      valid_reg <= 1'b0;
      xfer_reg  <= '0;
    end
    else
    begin
      s1_reg    <= {reg_select, rw, en, data_in};
      s2_reg    <= s1_reg;
      en_d_reg  <= en_s;
      low_reg   <= bus_width ? 1'b0 : (en_fall ? ~low_reg : low_reg);
      hi_reg    <= (en_fall & ~low_reg) ? d_s[7:4] : hi_reg;
      dout_reg  <= rsel;
      valid_reg <= done;
      xfer_reg  <= done ? '{rs: rs_s, rw: rw_s, data: wbyte} : xfer_reg;
    end
  end

  assign xfer       = xfer_reg;
  assign xfer_valid = valid_reg;
  assign cur_rs     = rs_s;
  assign data_out   = dout_reg;
  assign data_oe    = en_s & rw_s;

endmodule
`default_nettype wire

// file: rtl/cdis_top.sv
// Instruction decoder and executor of a 40x2 character display controller.
// Assumes host pins asynchronous to clk_sys; one 200 MHz clock domain.
// Functional notes
// - Clear fills display RAM with space, AC zero
// - Clear homes cursor and forces increment
// - Home zeroes AC, undoes shift, keeps RAM
// - Entry mode stores direction and shift flags
// - RAM access steps AC by direction flag
// - Glyph RAM accesses step AC the same way
// - Shift flag: display write shifts whole display
// - No shift on reads, glyph access, flag low
// - Display control stores on, cursor, blink flags
// - Cursor flag low hides cursor, keeps direction
// - Blink alternates all dots with character
// - Cursor shift moves AC, RAM untouched
// - Display shift moves view, AC unchanged
// - Two-line: past line one end, line two
// - Display shift wraps each line together
// - Function set picks bus width
// - Narrow bus moves bytes as two halves
// - Function set picks line count and font
// - Glyph address loads 6 bits, selects glyph
// - Display address loads 7 bits, selects display
// - Status read returns busy and AC
// - Data write stores to selected RAM
// - Select low: write instruction, read status
// - Display address ranges by line mode
`timescale 1ns/100ps
`default_nettype none
`include "cdis_consts.svh"
module cdis_top #(
  parameter int CLEAR_CYC = (`CDIS_T_CLEAR_NS + `CDIS_CLK_NS - 1)
                            / `CDIS_CLK_NS,
  parameter int HOME_CYC  = (`CDIS_T_HOME_NS + `CDIS_CLK_NS - 1)
                            / `CDIS_CLK_NS,
  parameter int CMD_CYC   = (`CDIS_T_CMD_NS + `CDIS_CLK_NS - 1)
                            / `CDIS_CLK_NS,
  parameter int DATA_CYC  = (`CDIS_T_DATA_NS + `CDIS_CLK_NS - 1)
                            / `CDIS_CLK_NS,
  parameter int BLINK_CYC = `CDIS_T_BLINK_NS / `CDIS_CLK_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        reg_select,
  input  wire logic        rw,
  input  wire logic        en,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  output logic             busy_flag,
  output logic             display_on,
  output logic             cursor_show,
  output logic             blink_mark,
  output logic             two_line,
  output logic             font_tall,
  output logic             bus_width,
  output logic      [6:0]  display_shift,
  output logic      [6:0]  cursor_addr
);

  cdis_pkg::cdis_xfer_t  xfer;
  cdis_pkg::cdis_state_t state_reg;
  cdis_pkg::cdis_state_t state_next;
  logic        xfer_valid;
  logic        cur_rs;
  logic [7:0]  rd_byte;
  logic [6:0]  ac_reg;
  logic [6:0]  ac_next;
  logic [6:0]  off_reg;
  logic [6:0]  off_next;
  logic [6:0]  fill_reg;
  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;
  logic [26:0] blink_cnt_reg;
  logic        blink_ph_reg;
  logic        glyph_reg;
  logic        dir_reg;
  logic        shen_reg;
  logic        don_reg;
  logic        cur_reg;
  logic        blink_reg;
  logic        wide_reg;
  logic        two_reg;
  logic        font_reg;
  logic [7:0]  ddr_rdata;
  logic [7:0]  cgr_rdata;

  // Next address after one step; lines wrap within the used range
  function automatic logic [6:0] ac_step(input logic [6:0] a,
                                         input logic       up,
                                         input logic       two,
                                         input logic       gly);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (gly)
      r = {1'b0, r[5:0]};
    else if (two && up && a == `CDIS_L1_END)
      r = `CDIS_L2_BASE;
    else if (two && up && a == `CDIS_L2_END)
      r = `CDIS_AC_ZERO;
    else if (two && !up && a == `CDIS_L2_BASE)
      r = `CDIS_L1_END;
    else if (two && !up && a == `CDIS_AC_ZERO)
      r = `CDIS_L2_END;
    else if (!two && up && a == `CDIS_ONE_END)
      r = `CDIS_AC_ZERO;
    else if (!two && !up && a == `CDIS_AC_ZERO)
      r = `CDIS_ONE_END;
    return r;
  endfunction

  // Display offset steps modulo one line, so every line wraps alike
  function automatic logic [6:0] off_step(input logic [6:0] o,
                                          input logic       left,
                                          input logic       two);
    logic [6:0] len;
    logic [6:0] r;
    len = two ? `CDIS_LEN_TWO : `CDIS_LEN_ONE;
    if (left)
      r = (o == 7'(len - 7'h01)) ? 7'h00 : 7'(o + 7'h01);
    else
      r = (o == 7'h00) ? 7'(len - 7'h01) : 7'(o - 7'h01);
    return r;
  endfunction

  cdis_bus u_bus (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .reg_select (reg_select),
    .rw         (rw),
    .en         (en),
    .data_in    (data_in),
    .bus_width  (wide_reg),
    .rd_byte    (rd_byte),
    .xfer       (xfer),
    .xfer_valid (xfer_valid),
    .cur_rs     (cur_rs),
    .data_out   (data_out),
    .data_oe    (data_oe)
  );

  // Decode; anything but a status read is dropped while busy
  wire       busy    = (state_reg != cdis_pkg::CDIS_IDLE);
  wire [7:0] d       = xfer.data;
  wire       take    = xfer_valid & ~busy;
  wire       ins     = take & ~xfer.rs & ~xfer.rw;
  wire       dat_wr  = take & xfer.rs & ~xfer.rw;
  wire       dat_rd  = take & xfer.rs & xfer.rw;
  wire       op_ddr  = ins & d[7];
  wire       op_cgr  = ins & (d[7:6] == 2'b01);
  wire       op_func = ins & (d[7:5] == 3'b001);
  wire       op_shft = ins & (d[7:4] == 4'b0001);
  wire       op_disp = ins & (d[7:3] == 5'b00001);
  wire       op_entr = ins & (d[7:2] == 6'b000001);
  wire       op_home = ins & (d[7:1] == 7'b0000001);
  wire       op_clr  = ins & (d == 8'h01);
  wire       op_cmd  = op_ddr | op_cgr | op_func | op_shft | op_disp
                       | op_entr;
  wire       ram_acc = dat_wr | dat_rd;
  wire       cur_mv  = op_shft & ~d[`CDIS_BIT_SC];
  wire       view_mv = op_shft & d[`CDIS_BIT_SC];
  // Whole-view shift on display writes only, flag set
  wire       wr_shft = dat_wr & shen_reg & ~glyph_reg;
  wire       filling = (state_reg == cdis_pkg::CDIS_FILL);
  wire       fill_end = filling & (fill_reg == `CDIS_FILL_LAST);
  wire       cnt_end = (cnt_reg == 20'h00000);
  wire       ddr_we  = filling | (dat_wr & ~glyph_reg);
  wire       cgr_we  = dat_wr & glyph_reg;
  wire [6:0] ddr_wa  = filling ? fill_reg : ac_reg;
  wire [7:0] ddr_wd  = filling ? `CDIS_SPACE : d;
  wire [7:0] ram_rd  = glyph_reg ? cgr_rdata : ddr_rdata;
  // Status costs no execution time and never sets busy
  assign rd_byte = cur_rs ? ram_rd : {busy, ac_reg};

  always_comb
  begin
    ac_next = ac_reg;
    if (op_clr | op_home)
      ac_next = `CDIS_AC_ZERO;
    else if (op_cgr)
      ac_next = {1'b0, d[5:0]};
    else if (op_ddr)
      ac_next = d[6:0];
    else if (cur_mv)
      ac_next = ac_step(ac_reg, d[`CDIS_BIT_RL], two_reg,
                        glyph_reg);
    else if (ram_acc)
      ac_next = ac_step(ac_reg, dir_reg, two_reg, glyph_reg);
  end

  always_comb
  begin
    off_next = off_reg;
    if (op_clr | op_home)
      off_next = 7'h00;
    else if (view_mv)
      off_next = off_step(off_reg, ~d[`CDIS_BIT_RL], two_reg);
    else if (wr_shft)
      off_next = off_step(off_reg, dir_reg, two_reg);
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      cdis_pkg::CDIS_IDLE:
      begin
        if (op_clr)
        begin
          state_next = cdis_pkg::CDIS_FILL;
          cnt_next   = 20'(CLEAR_CYC - 1);
        end
        else if (op_home | op_cmd | ram_acc)
        begin
          state_next = cdis_pkg::CDIS_WAIT;
          cnt_next   = op_home ? 20'(HOME_CYC - 1) :
                       ram_acc ? 20'(DATA_CYC - 1) : 20'(CMD_CYC - 1);
        end
      end
      cdis_pkg::CDIS_FILL:
      begin
        cnt_next = 20'(cnt_reg - 20'h00001);
        if (fill_end)
          state_next = cdis_pkg::CDIS_WAIT;
      end
      cdis_pkg::CDIS_WAIT:
      begin
        cnt_next = 20'(cnt_reg - 20'h00001);
        if (cnt_end)
          state_next = cdis_pkg::CDIS_IDLE;
      end
      default:
      begin
        state_next = cdis_pkg::CDIS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= cdis_pkg::CDIS_IDLE;
      cnt_reg   <= 20'h00000;
      ac_reg    <= `CDIS_AC_ZERO;
      off_reg   <= 7'h00;
      fill_reg  <= 7'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ac_reg    <= ac_next;
      off_reg   <= off_next;
      fill_reg  <= filling ? 7'(fill_reg + 7'h01) : 7'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      glyph_reg <= 1'b0;
      dir_reg   <= `CDIS_RST_DIR;
      shen_reg  <= 1'b0;
      don_reg   <= 1'b0;
      cur_reg   <= 1'b0;
      blink_reg <= 1'b0;
      wide_reg  <= `CDIS_RST_WIDE;
      two_reg   <= 1'b0;
      font_reg  <= 1'b0;
    end
    else
    begin
      glyph_reg <= op_cgr ? 1'b1 : (op_ddr ? 1'b0 : glyph_reg);
      dir_reg   <= op_clr ? 1'b1 :
                   (op_entr ? d[`CDIS_BIT_DIR] : dir_reg);
      shen_reg  <= op_entr ? d[`CDIS_BIT_SHIFT] : shen_reg;
      don_reg   <= op_disp ? d[`CDIS_BIT_DON] : don_reg;
      cur_reg   <= op_disp ? d[`CDIS_BIT_CUR] : cur_reg;
      blink_reg <= op_disp ? d[`CDIS_BIT_BLINK] : blink_reg;
      wide_reg  <= op_func ? d[`CDIS_BIT_DL] : wide_reg;
      two_reg   <= op_func ? d[`CDIS_BIT_N] : two_reg;
      font_reg  <= op_func ? d[`CDIS_BIT_F] : font_reg;
    end
  end

  // Blink phase runs free so the cursor rate never depends on the host
  wire blink_wrap = (blink_cnt_reg == 27'(BLINK_CYC - 1));

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blink_cnt_reg <= 27'h0000000;
      blink_ph_reg  <= 1'b0;
    end
    else
    begin
      blink_cnt_reg <= blink_wrap ? 27'h0000000
                                  : 27'(blink_cnt_reg + 27'h0000001);
      blink_ph_reg  <= blink_wrap ? ~blink_ph_reg : blink_ph_reg;
    end
  end

  cdis_ram #(
    .WIDTH  (8),
    .DEPTH  (128),
    .ADDR_W (7)
  ) u_ddr (
    .clk_sys (clk_sys),
    .we      (ddr_we),
    .waddr   (ddr_wa),
    .wdata   (ddr_wd),
    .raddr   (ac_reg),
    .rdata   (ddr_rdata)
  );

  cdis_ram #(
    .WIDTH  (8),
    .DEPTH  (64),
    .ADDR_W (6)
  ) u_cgr (
    .clk_sys (clk_sys),
    .we      (cgr_we),
    .waddr   (ac_reg[5:0]),
    .wdata   (d),
    .raddr   (ac_reg[5:0]),
    .rdata   (cgr_rdata)
  );

  // Display off keeps RAM intact; only the view outputs go dark
  assign busy_flag     = busy;
  assign display_on    = don_reg;
  assign cursor_show   = don_reg & cur_reg;
  assign blink_mark    = don_reg & blink_reg & blink_ph_reg;
  assign two_line      = two_reg;
  assign font_tall     = font_reg;
  assign bus_width     = wide_reg;
  assign display_shift = off_reg;
  assign cursor_addr   = ac_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence fill_run_s;
    (ddr_we && ddr_wd == 8'h20 && ddr_wa == 7'h00)
    ##1 (ddr_we && ddr_wd == 8'h20)[*7];
  endsequence

  sequence busy_run_s;
    busy_flag[*8];
  endsequence

  clear_fill_a: assert property (op_clr |=> fill_run_s)
    else $error("clear does not fill display RAM with space");
  clear_home_a: assert property (op_clr |=> ac_reg == 7'h00 && dir_reg
                                 && off_reg == 7'h00)
    else $error("clear does not home cursor and set increment");
  home_zero_a: assert property (op_home |=> ac_reg == 7'h00
                                && off_reg == 7'h00 && !ddr_we)
    else $error("home does not zero address and shift");
  entry_flags_a: assert property (op_entr |=> dir_reg == $past(d[1])
                                  && shen_reg == $past(d[0]))
    else $error("entry mode flags not stored");
  step_up_a: assert property (ram_acc && dir_reg && !glyph_reg
                              && ac_reg == 7'h00 |=> ac_reg == 7'h01)
    else $error("address does not step up after access");
  line_wrap_a: assert property (ram_acc && dir_reg && two_reg && !glyph_reg
                                && ac_reg == 7'h27 |=> ac_reg == 7'h40)
    else $error("two-line address does not move to second line");
  no_shift_a: assert property (dat_rd || (dat_wr && glyph_reg)
                               |=> $stable(off_reg))
    else $error("display shifted on read or glyph access");
  view_ac_a: assert property (view_mv |=> $stable(ac_reg))
    else $error("display shift changed the address");
  busy_hold_a: assert property ((op_cmd || ram_acc) |=> busy_run_s)
    else $error("busy not held after accepted instruction");
  refuse_a: assert property (busy && xfer_valid && !xfer.rw
                             |=> $stable(dir_reg) && $stable(wide_reg)
                             && $stable(don_reg) && $stable(ac_reg))
    else $error("instruction taken while busy");
  status_a: assert property (bus_width && !cur_rs |=> data_out ==
                             $past({busy_flag, cursor_addr}))
    else $error("status byte does not show busy and address");

endmodule
`default_nettype wire

// file: verif/cdis_host.sv
// Host model: drives the parallel pins, polls busy, reports reads.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps
`default_nettype none
module cdis_host (
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            reg_select,
  output logic            rw,
  output logic            en,
  output logic      [7:0] data_in,
  output logic            rd_done,
  output logic      [7:0] rd_byte
);
  logic       wide = 1'b1;
  logic       drive = 1'b0;
  logic [7:0] drv = 8'h00;
  // Released lines toggle so a stale byte is never seen as valid
  assign data_in = data_oe ? data_out : drv;
  always @(posedge clk_sys)
    if (!drive)
      drv <= ~drv;
  initial
  begin
    reg_select = 1'b0;
    rw = 1'b0;
    en = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // 100 clocks per strobe keeps the minimum enable period and setup
  task automatic pulse(input logic s, input logic r, input logic [7:0] v,
                       output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    reg_select = s;
    rw = r;
    drive = !r;
    drv = v;
    repeat (10) @(posedge clk_sys);
    #1;
    en = 1'b1;
    repeat (48) @(posedge clk_sys);
    #1;
    q = data_out;
    en = 1'b0;
    repeat (42) @(posedge clk_sys);
    #1;
    drive = 1'b0;
  endtask
  task automatic xfer(input logic s, input logic r, input logic [7:0] v,
                      output logic [7:0] q);
    logic [7:0] h;
    if (wide)
      pulse(s, r, v, q);
    else
    begin
      pulse(s, r, {v[7:4], ~v[7:4]}, h);
      pulse(s, r, {v[3:0], ~v[3:0]}, q);
      q = {h[7:4], q[7:4]};
    end
  endtask
  // Bounded; a stuck busy flag runs into the bench timeout
  task automatic poll();
    logic [7:0] q = 8'hFF;
    int         n = 0;
    while (q[7] !== 1'b0 && n < 50)
    begin
      xfer(1'b0, 1'b1, 8'h00, q);
      n++;
    end
  endtask
  task automatic rd(input logic s);
    logic [7:0] q;
    xfer(s, 1'b1, 8'h00, q);
    rd_byte = q;
    rd_done = 1'b1;
    @(posedge clk_sys);
    #1;
    rd_done = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verif/char_display_instruction_set_tb.sv
// Self-checking bench of the display instruction decoder.
// Assumes cdis_host drives the pins; reads are checked from a queue.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module char_display_instruction_set_tb;
  logic       clk_sys;
  logic       rst_b;
  logic       reg_select, rw, en, rd_done, data_oe, busy_flag;
  logic       display_on, cursor_show, blink_mark, two_line, font_tall;
  logic       bus_width;
  logic [7:0] data_in, data_out, rd_byte, q, got_e;
  logic [6:0] display_shift, cursor_addr;
  logic [7:0] exp_q[$];
  logic [7:0] dv[4];
  logic [6:0] av[4];
  int         fails = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         ones;
  cdis_top #(.CLEAR_CYC(400), .HOME_CYC(300), .CMD_CYC(300),
    .DATA_CYC(300), .BLINK_CYC(16)) uut (.clk_sys(clk_sys),
    .rst_b(rst_b), .reg_select(reg_select), .rw(rw), .en(en),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .busy_flag(busy_flag), .display_on(display_on),
    .cursor_show(cursor_show), .blink_mark(blink_mark),
    .two_line(two_line), .font_tall(font_tall), .bus_width(bus_width),
    .display_shift(display_shift), .cursor_addr(cursor_addr));
  cdis_host host (.clk_sys(clk_sys), .data_out(data_out),
    .data_oe(data_oe), .reg_select(reg_select), .rw(rw), .en(en),
    .data_in(data_in), .rd_done(rd_done), .rd_byte(rd_byte));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      end_sim();
    end
  end
  always @(posedge clk_sys)
    if (rd_done === 1'b1)
    begin
      got_e = exp_q.pop_front();
      `CHK(rd_byte, got_e)
    end
  task automatic cmd(input logic [7:0] b);
    host.xfer(1'b0, 1'b0, b, q);
    host.poll();
  endtask
  task automatic dat(input logic [7:0] b);
    host.xfer(1'b1, 1'b0, b, q);
    host.poll();
  endtask
  task automatic st(input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(1'b0);
  endtask
  task automatic rdd(input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(1'b1);
    host.poll();
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    rst_b = 1'b0;
    void'($urandom(25));
    repeat (4) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    `CHK(busy_flag, 1'b0)
    `CHK(data_oe, 1'b0)
    `CHK(bus_width, 1'b1)
    st(8'h00);
    cmd(8'h3C);
    `CHK({two_line, font_tall}, 2'b11)
    cmd(8'h38);
    `CHK({two_line, font_tall}, 2'b10)
    for (int i = 0; i < 8; i++)
    begin
      cmd(8'h08 | 8'(i));
      `CHK(display_on, i[2])
      `CHK(cursor_show, i[2] & i[1])
      if (!i[0])
        `CHK(blink_mark, 1'b0)
    end
    ones = 0;
    repeat (40)
    begin
      @(posedge clk_sys);
      ones += int'(blink_mark);
    end
    `CHK(ones > 0 && ones < 40, 1'b1)
    $display("test flags done");
    cmd(8'h06);
    cmd(8'hA7);
    host.xfer(1'b1, 1'b0, 8'h5A, q);
    st(8'hC0);
    host.xfer(1'b1, 1'b0, 8'h11, q);
    host.poll();
    st(8'h40);
    cmd(8'h08);
    cmd(8'hA7);
    rdd(8'h5A);
    st(8'h40);
    cmd(8'h04);
    cmd(8'hC0);
    dat(8'h33);
    st(8'h27);
    $display("test busy_step done");
    cmd(8'h07);
    cmd(8'h80);
    dat(8'h44);
    `CHK({display_shift, cursor_addr}, {7'h01, 7'h01})
    cmd(8'h80);
    rdd(8'h44);
    `CHK(display_shift, 7'h01)
    cmd(8'h7F);
    st(8'h3F);
    dat(8'h1F);
    `CHK({display_shift, cursor_addr}, {7'h01, 7'h00})
    cmd(8'h05);
    cmd(8'h85);
    dat(8'h00);
    `CHK({display_shift, cursor_addr}, {7'h00, 7'h04})
    cmd(8'h06);
    cmd(8'h10);
    `CHK(cursor_addr, 7'h03)
    cmd(8'h14);
    `CHK(cursor_addr, 7'h04)
    cmd(8'h1C);
    `CHK({display_shift, cursor_addr}, {7'h27, 7'h04})
    cmd(8'h18);
    `CHK(display_shift, 7'h00)
    cmd(8'h80);
    rdd(8'h44);
    cmd(8'h18);
    cmd(8'h02);
    `CHK({display_shift, cursor_addr}, 14'h0000)
    rdd(8'h44);
    $display("test shifts done");
    for (int i = 0; i < 4; i++)
    begin
      av[i] = 7'(i * 10 + $urandom % 10);
      dv[i] = 8'($urandom);
      cmd(8'h80 | {1'b0, av[i]});
      dat(dv[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      cmd(8'h80 | {1'b0, av[i]});
      rdd(dv[i]);
    end
    cmd(8'h30);
    cmd(8'hCF);
    dat(8'h55);
    st(8'h00);
    cmd(8'h38);
    host.xfer(1'b0, 1'b0, 8'h28, q);
    host.wide = 1'b0;
    host.poll();
    `CHK(bus_width, 1'b0)
    cmd(8'h85);
    dat(8'hA5);
    st(8'h06);
    cmd(8'h85);
    rdd(8'hA5);
    host.xfer(1'b0, 1'b0, 8'h38, q);
    host.wide = 1'b1;
    host.poll();
    `CHK(bus_width, 1'b1)
    $display("test data_modes done");
    cmd(8'h04);
    cmd(8'h01);
    st(8'h00);
    rdd(8'h20);
    st(8'h01);
    `CHK(display_shift, 7'h00)
    cmd(8'hA7);
    rdd(8'h20);
    $display("test clear done");
    repeat (2) @(posedge clk_sys);
    end_sim();
  end
endmodule
`default_nettype wire
